// [hdl/tpsc_pkg.sv]
// constants for the transmit power and synthesizer calibration register slice
package tpsc_pkg;
  localparam logic [5:0] TPSC_ADDR_TX_FRONTEND = 6'h22;
  localparam logic [5:0] TPSC_ADDR_PUMP_CAL = 6'h23;
  localparam logic [5:0] TPSC_ADDR_VCO_CAL = 6'h24;

  localparam int TPSC_PWR_LSB = 0;
  localparam int TPSC_PWR_MSB = 2;
  localparam int TPSC_LOBIAS_LSB = 4;
  localparam int TPSC_LOBIAS_MSB = 5;
  localparam int TPSC_CALCFG_LSB = 6;
  localparam int TPSC_CALCFG_MSB = 7;
  localparam int TPSC_PUMPEN_LSB = 4;
  localparam int TPSC_PUMPEN_MSB = 5;
  localparam int TPSC_PUMPRES_LSB = 0;
  localparam int TPSC_PUMPRES_MSB = 3;
  localparam int TPSC_VCOHI_BIT = 5;
  localparam int TPSC_VCORES_LSB = 0;
  localparam int TPSC_VCORES_MSB = 4;

  localparam logic [2:0] TPSC_PWR_RST = 3'h0;
  localparam logic [1:0] TPSC_LOBIAS_RST = 2'h1;
  localparam logic [1:0] TPSC_CALCFG_RST = 2'h2;
  localparam logic [1:0] TPSC_PUMPEN_RST = 2'h2;
  localparam logic [3:0] TPSC_PUMPRES_RST = 4'h9;
  localparam logic TPSC_VCOHI_RST = 1'b0;
  localparam logic [4:0] TPSC_VCORES_RST = 5'h0A;

  // power step spacing during ramps and keyed shaping
  localparam int TPSC_STEP_TIME_NS = 128;
  localparam int TPSC_CLK_PERIOD_NS = 8;
  localparam logic [7:0] TPSC_STEP_CYCLES =
    8'((TPSC_STEP_TIME_NS + TPSC_CLK_PERIOD_NS - 1) / TPSC_CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    TPSC_RAMP_IDLE = 3'b001,
    TPSC_RAMP_TX = 3'b010,
    TPSC_RAMP_DOWN = 3'b100
  } tpsc_ramp_t;
endpackage

// [hdl/tpsc_regs.sv]
// transmit power index, ramp sequencer and synthesizer calibration registers
`timescale 1ns/1ps
`default_nettype none
module tpsc_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [5:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata_q,
  output logic cfg_rvalid_q,
  input wire logic tx_active,
  input wire logic tx_ask_mode,
  input wire logic tx_symbol,
  input wire logic cal_done,
  input wire logic [3:0] cal_pump_result,
  input wire logic [4:0] cal_vco_result,
  output logic [2:0] pa_table_index_q,
  output logic pa_enable_q,
  output logic [1:0] tx_lo_buffer_bias_q,
  output logic [1:0] synth_cal_config_q,
  output logic pump_cal_stage_en_q,
  output logic [3:0] pump_current_code_q,
  output logic vco_core_high_select_q,
  output logic [4:0] vco_current_code_q
);
  logic [2:0] tx_power_index_q;
  logic [1:0] pump_cal_enable_q;
  logic [7:0] step_cnt_q;
  logic step_tick;
  logic [2:0] target_idx;
  tpsc_pkg::tpsc_ramp_t ramp_q;
  tpsc_pkg::tpsc_ramp_t ramp_d;

  function automatic logic wr_hit(input logic [5:0] addr);
    wr_hit = cfg_wr_en && (cfg_addr == addr);
  endfunction

  function automatic logic [7:0] read_word(input logic [5:0] addr);
    read_word = 8'h00;
    unique case (addr)
      tpsc_pkg::TPSC_ADDR_TX_FRONTEND:
      begin
        read_word[tpsc_pkg::TPSC_PWR_MSB:tpsc_pkg::TPSC_PWR_LSB] = tx_power_index_q;
        read_word[tpsc_pkg::TPSC_LOBIAS_MSB:tpsc_pkg::TPSC_LOBIAS_LSB] = tx_lo_buffer_bias_q;
      end
      tpsc_pkg::TPSC_ADDR_PUMP_CAL:
      begin
        read_word[tpsc_pkg::TPSC_CALCFG_MSB:tpsc_pkg::TPSC_CALCFG_LSB] = synth_cal_config_q;
        read_word[tpsc_pkg::TPSC_PUMPEN_MSB:tpsc_pkg::TPSC_PUMPEN_LSB] = pump_cal_enable_q;
        read_word[tpsc_pkg::TPSC_PUMPRES_MSB:tpsc_pkg::TPSC_PUMPRES_LSB] = pump_current_code_q;
      end
      tpsc_pkg::TPSC_ADDR_VCO_CAL:
      begin
        read_word[tpsc_pkg::TPSC_VCOHI_BIT] = vco_core_high_select_q;
        read_word[tpsc_pkg::TPSC_VCORES_MSB:tpsc_pkg::TPSC_VCORES_LSB] = vco_current_code_q;
      end
      default: read_word = 8'h00;
    endcase
  endfunction

  // reads return one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cfg_rdata_q <= 8'h00;
      cfg_rvalid_q <= 1'b0;
    end
    else
    begin
      cfg_rvalid_q <= cfg_rd_en;
      cfg_rdata_q <= cfg_rd_en ? read_word(cfg_addr) : 8'h00;
    end
  end

  // transmit front-end fields; bits 7:6 and 3 are not stored
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tx_power_index_q <= tpsc_pkg::TPSC_PWR_RST;
      tx_lo_buffer_bias_q <= tpsc_pkg::TPSC_LOBIAS_RST;
    end
    else if (wr_hit(tpsc_pkg::TPSC_ADDR_TX_FRONTEND))
    begin
      tx_power_index_q <= cfg_wdata[tpsc_pkg::TPSC_PWR_MSB:tpsc_pkg::TPSC_PWR_LSB];
      tx_lo_buffer_bias_q <= cfg_wdata[tpsc_pkg::TPSC_LOBIAS_MSB:tpsc_pkg::TPSC_LOBIAS_LSB];
    end
  end

  // pump calibration register; a finished calibration with the pump stage enabled beats a host write to the current code in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      synth_cal_config_q <= tpsc_pkg::TPSC_CALCFG_RST;
      pump_cal_enable_q <= tpsc_pkg::TPSC_PUMPEN_RST;
      pump_current_code_q <= tpsc_pkg::TPSC_PUMPRES_RST;
      pump_cal_stage_en_q <= (tpsc_pkg::TPSC_PUMPEN_RST != 2'h0);
    end
    else
    begin
      if (wr_hit(tpsc_pkg::TPSC_ADDR_PUMP_CAL))
      begin
        synth_cal_config_q <= cfg_wdata[tpsc_pkg::TPSC_CALCFG_MSB:tpsc_pkg::TPSC_CALCFG_LSB];
        pump_cal_enable_q <= cfg_wdata[tpsc_pkg::TPSC_PUMPEN_MSB:tpsc_pkg::TPSC_PUMPEN_LSB];
        pump_current_code_q <=
          cfg_wdata[tpsc_pkg::TPSC_PUMPRES_MSB:tpsc_pkg::TPSC_PUMPRES_LSB];
      end
      if (cal_done && pump_cal_stage_en_q)
        pump_current_code_q <= cal_pump_result;
      pump_cal_stage_en_q <= (pump_cal_enable_q != 2'h0);
    end
  end

  // vco calibration register; the host current code acts as an override until the next calibration, the core select is never replaced
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      vco_core_high_select_q <= tpsc_pkg::TPSC_VCOHI_RST;
      vco_current_code_q <= tpsc_pkg::TPSC_VCORES_RST;
    end
    else
    begin
      if (wr_hit(tpsc_pkg::TPSC_ADDR_VCO_CAL))
      begin
        vco_core_high_select_q <= cfg_wdata[tpsc_pkg::TPSC_VCOHI_BIT];
        vco_current_code_q <=
          cfg_wdata[tpsc_pkg::TPSC_VCORES_MSB:tpsc_pkg::TPSC_VCORES_LSB];
      end
      if (cal_done)
        vco_current_code_q <= cal_vco_result;
    end
  end

  // free running divider gives the power step rate
  assign step_tick = (step_cnt_q == tpsc_pkg::TPSC_STEP_CYCLES - 8'h01);
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || step_tick)
      step_cnt_q <= 8'h00;
    else
      step_cnt_q <= step_cnt_q + 8'h01;
  end

  always_comb
  begin
    ramp_d = ramp_q;
    target_idx = 3'h0;
    unique case (ramp_q)
      tpsc_pkg::TPSC_RAMP_IDLE:
        if (tx_active)
          ramp_d = tpsc_pkg::TPSC_RAMP_TX;
      tpsc_pkg::TPSC_RAMP_TX:
      begin
        // keyed symbols aim at entry zero or the index; other formats hold the index
        target_idx = (tx_ask_mode && !tx_symbol) ? 3'h0 : tx_power_index_q;
        if (!tx_active)
          ramp_d = tpsc_pkg::TPSC_RAMP_DOWN;
      end
      tpsc_pkg::TPSC_RAMP_DOWN:
        if (tx_active)
          ramp_d = tpsc_pkg::TPSC_RAMP_TX;
        else if (pa_table_index_q == 3'h0)
          ramp_d = tpsc_pkg::TPSC_RAMP_IDLE;
      default: ramp_d = tpsc_pkg::TPSC_RAMP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ramp_q <= tpsc_pkg::TPSC_RAMP_IDLE;
    else
      ramp_q <= ramp_d;
  end

  // one table entry per step keeps the amplifier from jumping between levels
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pa_table_index_q <= 3'h0;
      pa_enable_q <= 1'b0;
    end
    else
    begin
      pa_enable_q <= (ramp_d != tpsc_pkg::TPSC_RAMP_IDLE);
      if (step_tick && pa_table_index_q < target_idx)
        pa_table_index_q <= pa_table_index_q + 3'h1;
      else if (step_tick && pa_table_index_q > target_idx)
        pa_table_index_q <= pa_table_index_q - 3'h1;
    end
  end

  property p_pwr_write;
    @(posedge core_clk) disable iff (sys_rst)
    wr_hit(tpsc_pkg::TPSC_ADDR_TX_FRONTEND) |=> tx_power_index_q == $past(cfg_wdata[2:0]);
  endproperty
  a_pwr_write: assert property (p_pwr_write) else $error("power index not written");

  property p_key_one;
    @(posedge core_clk) disable iff (sys_rst)
    (ramp_q == tpsc_pkg::TPSC_RAMP_TX && tx_active && (!tx_ask_mode || tx_symbol)
     && step_tick && pa_table_index_q < tx_power_index_q)
    |=> pa_table_index_q == $past(pa_table_index_q) + 3'h1;
  endproperty
  a_key_one: assert property (p_key_one) else $error("no step up toward index");

  property p_key_zero;
    @(posedge core_clk) disable iff (sys_rst)
    (ramp_q == tpsc_pkg::TPSC_RAMP_TX && tx_ask_mode && !tx_symbol && step_tick
     && pa_table_index_q != 3'h0)
    |=> pa_table_index_q == $past(pa_table_index_q) - 3'h1;
  endproperty
  a_key_zero: assert property (p_key_zero) else $error("no step down toward zero");

  property p_step_paced;
    @(posedge core_clk) disable iff (sys_rst)
    $changed(pa_table_index_q) |-> $past(step_tick);
  endproperty
  a_step_paced: assert property (p_step_paced) else $error("index moved without tick");

  property p_ramp_end;
    @(posedge core_clk) disable iff (sys_rst)
    (ramp_q == tpsc_pkg::TPSC_RAMP_DOWN && !tx_active && pa_table_index_q == 3'h0)
    |=> ramp_q == tpsc_pkg::TPSC_RAMP_IDLE && !pa_enable_q;
  endproperty
  a_ramp_end: assert property (p_ramp_end) else $error("ramp down did not finish");

  property p_bias_write;
    @(posedge core_clk) disable iff (sys_rst)
    wr_hit(tpsc_pkg::TPSC_ADDR_TX_FRONTEND) |=> tx_lo_buffer_bias_q == $past(cfg_wdata[5:4]);
  endproperty
  a_bias_write: assert property (p_bias_write) else $error("bias not written");

  property p_cfg_write;
    @(posedge core_clk) disable iff (sys_rst)
    wr_hit(tpsc_pkg::TPSC_ADDR_PUMP_CAL) |=> synth_cal_config_q == $past(cfg_wdata[7:6]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("cal config not written");

  property p_pump_gated;
    @(posedge core_clk) disable iff (sys_rst)
    (cal_done && !pump_cal_stage_en_q && !wr_hit(tpsc_pkg::TPSC_ADDR_PUMP_CAL))
    |=> $stable(pump_current_code_q);
  endproperty
  a_pump_gated: assert property (p_pump_gated) else $error("pump result without enable");

  property p_pump_store;
    @(posedge core_clk) disable iff (sys_rst)
    (cal_done && pump_cal_stage_en_q) |=> pump_current_code_q == $past(cal_pump_result);
  endproperty
  a_pump_store: assert property (p_pump_store) else $error("pump result lost");

  property p_vco_store;
    @(posedge core_clk) disable iff (sys_rst)
    cal_done |=> vco_current_code_q == $past(cal_vco_result);
  endproperty
  a_vco_store: assert property (p_vco_store) else $error("vco result lost");

  property p_vco_override;
    @(posedge core_clk) disable iff (sys_rst)
    (wr_hit(tpsc_pkg::TPSC_ADDR_VCO_CAL) && !cal_done)
    |=> vco_current_code_q == $past(cfg_wdata[4:0])
        && vco_core_high_select_q == $past(cfg_wdata[5]);
  endproperty
  a_vco_override: assert property (p_vco_override) else $error("vco override lost");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (sys_rst)
    (cfg_rd_en && cfg_addr == tpsc_pkg::TPSC_ADDR_TX_FRONTEND)
    |=> cfg_rdata_q[7:6] == 2'h0 && !cfg_rdata_q[3];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
endmodule
`default_nettype wire

// [verif/tpsc_host_model.sv]
// host controller model driving the configuration port of the register slice
`timescale 1ns/1ps
`default_nettype none
module tpsc_host_model (
  input wire logic core_clk,
  output logic cfg_wr_en,
  output logic cfg_rd_en,
  output logic [5:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata_q,
  input wire logic cfg_rvalid_q
);
  logic [7:0] saved_pump;
  logic [7:0] saved_vco;
  initial
  begin
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b0;
    cfg_addr = 6'h00;
    cfg_wdata = 8'h00;
  end
  // released data shows the inverse so a stale value cannot pass for a fresh one
  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge core_clk);
    #1;
    cfg_wr_en = 1'b0;
    cfg_wdata = ~d;
  endtask
  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    cfg_rd_en = 1'b1;
    cfg_addr = a;
    @(posedge core_clk);
    #1;
    cfg_rd_en = 1'b0;
    d = cfg_rvalid_q ? cfg_rdata_q : 8'hXX;
  endtask
  // keep one channel's calibration words for a later hop
  task automatic save_cal();
    reg_read(6'h23, saved_pump);
    reg_read(6'h24, saved_vco);
  endtask
  // the whole pump word goes back, so the configuration field is reloaded too
  task automatic restore_cal();
    reg_write(6'h23, saved_pump);
    reg_write(6'h24, saved_vco);
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the transmit power and calibration registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, sys_rst, cfg_wr_en, cfg_rd_en, cfg_rvalid_q, cal_done;
  logic tx_active, tx_ask_mode, tx_symbol, pa_enable_q, pump_cal_stage_en_q;
  logic vco_core_high_select_q;
  logic [5:0] cfg_addr;
  logic [7:0] cfg_wdata, cfg_rdata_q, rd;
  logic [3:0] cal_pump_result, pump_current_code_q;
  logic [4:0] cal_vco_result, vco_current_code_q;
  logic [2:0] pa_table_index_q, idx_prev;
  logic [1:0] tx_lo_buffer_bias_q, synth_cal_config_q;
  int err_total = 0;
  int cmp_count = 0;
  tpsc_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q), .tx_active(tx_active),
    .tx_ask_mode(tx_ask_mode), .tx_symbol(tx_symbol), .cal_done(cal_done),
    .cal_pump_result(cal_pump_result), .cal_vco_result(cal_vco_result),
    .pa_table_index_q(pa_table_index_q), .pa_enable_q(pa_enable_q),
    .tx_lo_buffer_bias_q(tx_lo_buffer_bias_q), .synth_cal_config_q(synth_cal_config_q),
    .pump_cal_stage_en_q(pump_cal_stage_en_q), .pump_current_code_q(pump_current_code_q),
    .vco_core_high_select_q(vco_core_high_select_q),
    .vco_current_code_q(vco_current_code_q));
  tpsc_host_model host (.core_clk(core_clk), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rvalid_q(cfg_rvalid_q));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    host.reg_read(a, rd);
    chk(rd, exp);
  endtask
  task automatic cal_pulse(input logic [3:0] p, input logic [4:0] v);
    @(posedge core_clk);
    #1;
    cal_done = 1'b1;
    cal_pump_result = p;
    cal_vco_result = v;
    @(posedge core_clk);
    #1;
    cal_done = 1'b0;
    cal_pump_result = ~p;
    cal_vco_result = ~v;
  endtask
  // bounded wait: a few steps of 16 cycles each fit well inside 200
  task automatic wait_idx(input logic [2:0] v);
    int n;
    n = 0;
    while (pa_table_index_q !== v && n < 200)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk({5'h0, pa_table_index_q}, {5'h0, v});
  endtask
  // the index must never jump: every change is one table step
  always @(posedge core_clk)
  begin
    if (!sys_rst && idx_prev !== pa_table_index_q)
      chk({7'h0, (pa_table_index_q - idx_prev) inside {3'h1, 3'h7}}, 8'h01);
    idx_prev <= pa_table_index_q;
  end
  // whole run is a few hundred cycles; this leaves a wide margin
  initial
  begin
    #200000;
    err_total++;
    stop_test();
  end
  initial
  begin
    sys_rst = 1'b1;
    cal_done = 1'b0;
    cal_pump_result = 4'h0;
    cal_vco_result = 5'h00;
    tx_active = 1'b0;
    tx_ask_mode = 1'b0;
    tx_symbol = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    rd_chk(6'h22, 8'h10);
    rd_chk(6'h23, 8'hA9);
    rd_chk(6'h24, 8'h0A);
    chk({7'h0, pump_cal_stage_en_q}, 8'h01);
    $display("test reset values done");
    host.reg_write(6'h22, 8'hFF);
    rd_chk(6'h22, 8'h37);
    chk({6'h0, tx_lo_buffer_bias_q}, 8'h03);
    host.reg_write(6'h24, 8'hFF);
    rd_chk(6'h24, 8'h3F);
    chk({7'h0, vco_core_high_select_q}, 8'h01);
    host.reg_write(6'h24, 8'h00);
    chk({7'h0, vco_core_high_select_q}, 8'h00);
    host.reg_write(6'h25, 8'h55);
    rd_chk(6'h25, 8'h00);
    $display("test access kinds done");
    host.reg_write(6'h23, 8'h89);
    repeat (2) @(posedge core_clk);
    cal_pulse(4'h5, 5'h11);
    chk({4'h0, pump_current_code_q}, 8'h09);
    chk({3'h0, vco_current_code_q}, 8'h11);
    chk({7'h0, pump_cal_stage_en_q}, 8'h00);
    host.reg_write(6'h23, 8'h99);
    repeat (2) @(posedge core_clk);
    cal_pulse(4'h5, 5'h12);
    chk({4'h0, pump_current_code_q}, 8'h05);
    rd_chk(6'h23, 8'h95);
    host.save_cal();
    host.reg_write(6'h24, 8'h03);
    chk({3'h0, vco_current_code_q}, 8'h03);
    host.reg_write(6'h23, 8'h40);
    host.restore_cal();
    chk({4'h0, pump_current_code_q}, 8'h05);
    chk({3'h0, vco_current_code_q}, 8'h12);
    chk({6'h0, synth_cal_config_q}, 8'h02);
    $display("test calibration and hop done");
    host.reg_write(6'h22, 8'h03);
    tx_ask_mode = 1'b1;
    tx_symbol = 1'b1;
    tx_active = 1'b1;
    wait_idx(3'h3);
    chk({7'h0, pa_enable_q}, 8'h01);
    tx_symbol = 1'b0;
    wait_idx(3'h0);
    chk({7'h0, pa_enable_q}, 8'h01);
    tx_symbol = 1'b1;
    wait_idx(3'h3);
    tx_active = 1'b0;
    wait_idx(3'h0);
    repeat (3) @(posedge core_clk);
    #1;
    chk({7'h0, pa_enable_q}, 8'h00);
    tx_ask_mode = 1'b0;
    tx_symbol = 1'b0;
    tx_active = 1'b1;
    wait_idx(3'h3);
    tx_active = 1'b0;
    wait_idx(3'h0);
    $display("test power ramp done");
    stop_test();
  end
endmodule
`default_nettype wire
